// [pkg/event_flags_defines.vh]
// Register offsets, field positions and reset values for the event flag bank
`ifndef EVENT_FLAGS_DEFINES_VH
`define EVENT_FLAGS_DEFINES_VH
`define FLAG_REG_ADDR 8'h2b
`define MINUTES_REG_ADDR 8'h02
`define FLAG_RESET 4'h0
`define BIT_BATTERY_SWITCHOVER 3
`define BIT_STAMP_THREE 2
`define BIT_STAMP_TWO 1
`define BIT_STAMP_ONE 0
`define MONITOR_BIT 7
`endif

// [logic/event_flag_status_register.v]
// Event flag status register with write-AND clearing and event monitor
//
// Notes on behaviour
// - Battery switch-over flag reads 1 while latched; writing 1 keeps it.
// - Battery switch-over flag is bit 3, resets 0, cleared by writing 0.
// - Stamp three flag is bit 2, resets 0; write 0 clears, 1 keeps.
// - Stamp two flag is bit 1, resets 0; write 0 clears, 1 keeps.
// - Stamp one flag is bit 0, resets 0; write 0 clears, 1 keeps.
// - Only the owning function sets a flag; it stays until host clears it.
// - Host write stores written byte ANDed with current flags.
// - Monitor is high when any flag set; reads as minutes register MSB.
`timescale 1ns/10ps
`default_nettype none
`include "event_flags_defines.vh"

module event_flag_status_register (
    input wire sys_clk_in,
    input wire srst_in,
    input wire [3:0] flag_set_in,
    input wire wr_en_in,
    input wire rd_en_in,
    input wire [7:0] addr_in,
    input wire [7:0] wr_data_in,
    input wire [6:0] minutes_low_in,
    output reg [7:0] rd_data_out,
    output reg [3:0] flags_out,
    output reg any_event_monitor_out
);

    // Width of the flag field in the bank
    localparam FLAG_COUNT = 4;
    // Bits 7:4 of the flag byte are not held here and read back as zero
    localparam [3:0] UPPER_ZERO = 4'h0;

    // Read source codes
    localparam [1:0] RD_HOLD = 2'b00;
    localparam [1:0] RD_FLAGS = 2'b01;
    localparam [1:0] RD_MINUTES = 2'b10;
    localparam [1:0] RD_ZERO = 2'b11;

    // Flag state and its next value
    reg [3:0] flags_q;
    wire [3:0] flags_d;

    // Read source choice and read data next value
    reg [1:0] rd_sel;
    reg [7:0] rd_data_d;

    // Decoded bus strobes
    wire flag_wr;
    wire flag_rd;
    wire minutes_rd;
    wire other_rd;

    // Per-bit write mask; one keeps a flag, zero drops it
    wire [3:0] keep_mask;

    // Named views of the stored flags
    wire battery_switchover_flag;
    wire stamp_three_event_flag;
    wire stamp_two_event_flag;
    wire stamp_one_event_flag;

    // Monitor views: current state for reads, next state for the pin copy
    wire any_event_now;
    wire any_event_next;

    // Flag register decode, shared by the write and the read path
    function is_flag_addr;
        input [7:0] addr;
        begin
            is_flag_addr = (addr == `FLAG_REG_ADDR);
        end
    endfunction

    // Minutes register decode; only its MSB comes from this bank
    function is_minutes_addr;
        input [7:0] addr;
        begin
            is_minutes_addr = (addr == `MINUTES_REG_ADDR);
        end
    endfunction

    // OR of a flag set, used for the current and the next monitor
    function any_flag;
        input [3:0] flags;
        begin
            any_flag = |flags;
        end
    endfunction

    // Flag byte as the host sees it; upper bits always read zero
    function [7:0] flag_byte;
        input battery;
        input stamp_three;
        input stamp_two;
        input stamp_one;
        begin
            flag_byte = {UPPER_ZERO, 4'h0};
            flag_byte[`BIT_BATTERY_SWITCHOVER] = battery;
            flag_byte[`BIT_STAMP_THREE] = stamp_three;
            flag_byte[`BIT_STAMP_TWO] = stamp_two;
            flag_byte[`BIT_STAMP_ONE] = stamp_one;
        end
    endfunction

    // Minutes byte: monitor on top, counter bits below
    function [7:0] minutes_byte;
        input monitor;
        input [6:0] minutes_low;
        begin
            minutes_byte = {1'b0, minutes_low};
            minutes_byte[`MONITOR_BIT] = monitor;
        end
    endfunction

    // Strobe decode; writes elsewhere are ignored by this bank
    assign flag_wr = wr_en_in && is_flag_addr(addr_in);
    assign flag_rd = rd_en_in && is_flag_addr(addr_in);
    assign minutes_rd = rd_en_in && is_minutes_addr(addr_in);
    assign other_rd = rd_en_in && !flag_rd && !minutes_rd;

    // Named flag views at their register positions
    assign battery_switchover_flag = flags_q[`BIT_BATTERY_SWITCHOVER];
    assign stamp_three_event_flag = flags_q[`BIT_STAMP_THREE];
    assign stamp_two_event_flag = flags_q[`BIT_STAMP_TWO];
    assign stamp_one_event_flag = flags_q[`BIT_STAMP_ONE];

    // Per-flag next state, identical for every bit
    genvar i;
    generate
        for (i = 0; i < FLAG_COUNT; i = i + 1) begin : g_flag
            wire set_req;
            wire clear_req;
            // Owner request for this bit
            assign set_req = flag_set_in[i];
            // a written zero drops the bit, a one keeps it
            assign clear_req = flag_wr & ~wr_data_in[i];
            assign keep_mask[i] = ~clear_req;
            // only the owner sets; set beats a same-cycle clear
            assign flags_d[i] = (flags_q[i] & keep_mask[i]) | set_req;
        end
    endgenerate

    // monitor is OR of all flags
    assign any_event_now = any_flag(flags_q);
    assign any_event_next = any_flag(flags_d);

    // Flag storage; a set request during reset is dropped
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            flags_q <= `FLAG_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Pin copy of the flags, loaded with the same next value as the storage
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            flags_out <= `FLAG_RESET;
        end else begin
            flags_out <= flags_d;
        end
    end

    // Pin copy of the monitor; registered so the pin never glitches
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            any_event_monitor_out <= 1'b0;
        end else begin
            any_event_monitor_out <= any_event_next;
        end
    end

    // Read source; a read samples the flags before a same-cycle write
    always @* begin
        rd_sel = RD_HOLD;
        if (flag_rd) begin
            rd_sel = RD_FLAGS;
        end else if (minutes_rd) begin
            rd_sel = RD_MINUTES;
        end else if (other_rd) begin
            rd_sel = RD_ZERO;
        end
    end

    // Read data select; without a read the last value stands
    always @* begin
        case (rd_sel)
            RD_FLAGS: begin
                rd_data_d = flag_byte(battery_switchover_flag, stamp_three_event_flag,
                    stamp_two_event_flag, stamp_one_event_flag);
            end
            RD_MINUTES: begin
                rd_data_d = minutes_byte(any_event_now, minutes_low_in);
            end
            RD_ZERO: begin
                // Unmapped addresses read zero
                rd_data_d = 8'h00;
            end
            default: begin
                rd_data_d = rd_data_out;
            end
        endcase
    end

    // Read data register; holds its value until the next read
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            rd_data_out <= 8'h00;
        end else begin
            rd_data_out <= rd_data_d;
        end
    end

endmodule
`default_nettype wire

// [dv/efs_checker.sv]
// Flag bank checker
`timescale 1ns/10ps
`default_nettype none
module efs_checker (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic any_event_monitor_out,
    input wire logic [3:0] flag_set_in,
    input wire logic [3:0] flags_out,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [6:0] minutes_low_in,
    input wire logic [7:0] rd_data_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    a_and_clear: assert property (wr_en_in && addr_in == 8'h2b |=> flags_out ==
        ($past(flags_out) & $past(wr_data_in[3:0]) | $past(flag_set_in))) else $error("and");
    a_flag_hold: assert property (!(wr_en_in && addr_in == 8'h2b) |=> flags_out ==
        ($past(flags_out) | $past(flag_set_in))) else $error("hold");
    a_monitor_or: assert property (any_event_monitor_out == |flags_out) else $error("mon");
    a_reset_zero: assert property (disable iff (1'b0) srst_in |=>
        flags_out == 4'h0 && !any_event_monitor_out && rd_data_out == 8'h00) else $error("rst");
    a_read_flags: assert property (rd_en_in && addr_in == 8'h2b |=>
        rd_data_out == {4'h0, $past(flags_out)}) else $error("rdflags");
    a_read_minutes: assert property (rd_en_in && addr_in == 8'h02 |=>
        rd_data_out == {$past(any_event_monitor_out), $past(minutes_low_in)}) else $error("rdmin");
endmodule
bind event_flag_status_register efs_checker chk(.*);
`default_nettype wire

// [dv/efs_host.sv]
// Host model for register strobes
`timescale 1ns/10ps
`default_nettype none
module efs_host(input wire clk, output logic we = 0, re = 0, output logic [7:0] a = 0, d = 0);
    task acc(input logic w, input logic [7:0] ad, dt);
        @(posedge clk) {we, re, a, d} <= {w, !w, ad, dt};
        @(posedge clk) {we, re, d} <= {2'b00, ~dt}; // Released data inverted
    endtask
endmodule
`default_nettype wire

// [dv/event_flag_status_register_tb_top.sv]
// Bench for the flag bank
`timescale 1ns/10ps
`default_nettype none
module event_flag_status_register_tb_top;
    logic clk = 0, rst = 1;
    logic [3:0] set = 0;
    int mismatches = 0, n_checks = 0, cyc = 0;
    wire we, re, mon;
    wire [7:0] a, d, rd;
    wire [3:0] fl;
    always #4 clk = ~clk;
    efs_host host(.clk(clk), .we(we), .re(re), .a(a), .d(d));
    event_flag_status_register dut(.sys_clk_in(clk), .srst_in(rst), .flag_set_in(set),
        .wr_en_in(we), .rd_en_in(re), .addr_in(a), .wr_data_in(d), .minutes_low_in(7'h2a),
        .rd_data_out(rd), .flags_out(fl), .any_event_monitor_out(mon));
    task chk(input string n, input logic [7:0] s, e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task t_clear;
        @(posedge clk) set <= 4'hf;
        @(posedge clk) set <= 4'h0;
        host.acc(1, 8'h2b, 8'hfa);
        #1 chk("flags", fl, 4'ha);
        host.acc(0, 8'h2b, 8'h00);
        #1 chk("rd", rd, 8'h0a);
        host.acc(1, 8'h2b, 8'h00);
        #1 chk("clr", {mon, fl}, 5'h00);
    endtask
    task t_minutes;
        @(posedge clk) set <= 4'h1;
        @(posedge clk) set <= 4'h0;
        host.acc(0, 8'h02, 8'h00);
        #1 chk("min", rd, 8'haa);
        host.acc(0, 8'h30, 8'h00);
        #1 chk("unmapped", rd, 8'h00);
        host.acc(1, 8'h2b, 8'hfe);
        host.acc(0, 8'h02, 8'h00);
        #1 chk("min_idle", rd, 8'h2a);
    endtask
    task t_single;
        @(posedge clk) set <= 4'hf;
        @(posedge clk) set <= 4'h0;
        // ones on every bit to keep
        host.acc(1, 8'h2b, 8'hfe);
        #1 chk("clr_one", fl, 4'he);
        host.acc(1, 8'h2b, 8'hfd);
        #1 chk("clr_two", fl, 4'hc);
        host.acc(1, 8'h2b, 8'hfb);
        #1 chk("clr_three", fl, 4'h8);
        host.acc(0, 8'h2b, 8'h00);
        #1 chk("rd_batt", rd, 8'h08);
        host.acc(1, 8'h2b, 8'hf7);
        #1 chk("clr_batt", {mon, fl}, 5'h00);
    endtask
    task t_set_wins;
        @(posedge clk) set <= 4'h2;
        host.acc(1, 8'h2b, 8'h00);
        #1 chk("set_wins", fl, 4'h2);
        @(posedge clk) set <= 4'h0;
        host.acc(1, 8'h2b, 8'hf0);
        #1 chk("upper_ignored", {mon, fl}, 5'h00);
    endtask
    always @(posedge clk) if (++cyc > 500) begin mismatches++; stop_test; end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        #1 chk("reset", fl, 4'h0);
        t_clear;
        t_single;
        t_set_wins;
        t_minutes;
        stop_test;
    end
endmodule
`default_nettype wire
